// ===== rtl/sfc_pkg.sv
// Constants, state layout and types of the serial flash command block.
// Assumes a 40 MHz system clock that samples all pin inputs.
package sfc_pkg;
    localparam int CLK_HZ = 40_000_000;

    localparam int STATUS_WRITE_TIME_NS = 5000;
    localparam int SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int SLEEP_RECOVERY_NS    = 3000;
    localparam logic [15:0] STATUS_WRITE_CYC = 16'((STATUS_WRITE_TIME_NS * 40 + 999) / 1000);
    localparam logic [15:0] SLEEP_ENTRY_CYC  = 16'((SLEEP_ENTRY_DELAY_NS * 40 + 999) / 1000);
    localparam logic [15:0] SLEEP_RECOV_CYC  = 16'((SLEEP_RECOVERY_NS * 40 + 999) / 1000);

    localparam logic [7:0] OP_STATUS_READ   = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] OP_DEEP_SLEEP    = 8'hb9;
    localparam logic [7:0] OP_RELEASE_ID    = 8'hab;
    localparam logic [7:0] OP_STD_ID        = 8'h9f;

    // Status byte layout
    localparam int ST_BUSY_POS = 0;
    localparam int ST_WEL_POS  = 1;
    localparam int ST_BP_POS   = 2;
    localparam int ST_TB_POS   = 5;
    localparam int ST_BPL_POS  = 7;
    localparam logic [2:0] PROTECT_RST = 3'h0;

    // Register map
    localparam logic [7:0] REG_STATUS  = 8'h00;
    localparam logic [7:0] REG_CONTROL = 8'h04;
    localparam int CTL_EXT_BUSY_POS = 0;

    typedef enum logic [4:0] {
        PH_IDLE = 5'b00001,
        PH_CMD  = 5'b00010,
        PH_ADDR = 5'b00100,
        PH_OUT  = 5'b01000,
        PH_DATA = 5'b10000
    } sfc_phase_t;

    typedef struct packed {
        logic        ce_m, ce_s, ce_q;
        logic        sck_m, sck_s, sck_q;
        logic        si_m, si_s;
        logic        wp_m, wp_s;
        sfc_phase_t  phase;
        logic [2:0]  bit_cnt;
        logic [1:0]  byte_cnt;
        logic [7:0]  shreg;
        logic [7:0]  opcode;
        logic        cmd_ok;
        logic [7:0]  wdata;
        logic [7:0]  cur;
        logic [2:0]  ocnt;
        logic [1:0]  idx;
        logic        wel;
        logic [2:0]  bp;
        logic        tb;
        logic        status_lockdown_bit;
        logic [15:0] wr_cnt;
        logic        sleep;
        logic [15:0] pwr_cnt;
        logic        ext_busy;
        logic        so;
        logic        so_oe;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sfc_state_t;
endpackage

// ===== rtl/sfc_flash_cmd.sv
// Serial flash command interpreter: status, write latch, lock-down,
// deep sleep and identification, with an APB status/control port.
// Assumes SPI pins asynchronous to sys_clk, SCK at most sys_clk/8.
//
// Summary of operation
// - Opcode 05h returns the status byte whenever awake, even while busy.
// - Status bytes repeat while clocks continue, stopping only at chip enable high.
// - Opcode 06h sets the write-enable latch.
// - Chip enable rising after a status write clears the write-enable latch.
// - Write enable and disable act only on the closing chip-enable rise.
// - Opcode 04h clears the write-enable latch.
// - Status write changes only protect bits, top/bottom select and lock-down bit.
// - Status write runs a self-timed busy cycle; host polls or waits.
// - Status write is ignored when protect pin low and lock-down set.
// - With protect pin low the lock-down bit may only be set.
// - With protect pin high all five writable bits change freely.
// - Lock checks happen at chip-enable rise; one write may lock and protect.
// - Opcode B9h enters deep sleep only at the closing chip-enable rise.
// - Deep sleep command is ignored while an internal write is busy.
// - In deep sleep only release and legacy identification are accepted.
// - Lowest power is reached only after the sleep entry delay.
// - Opcode ABh framed by chip enable releases sleep after recovery time.
// - ABh plus 24 dummy bits outputs the one-byte identifier repeatedly.
// - Opcode 9Fh outputs maker, type, capacity and reserved bytes.
// - The four identifier bytes repeat; chip enable high ends output anywhere.
// - Write-type commands need chip enable rise on a whole byte boundary.
// - Status write with two or more data bytes is rejected.
module sfc_flash_cmd
    import sfc_pkg::*;
#(
    parameter logic [7:0]  LEGACY_ID = 8'h7a,        // Arbitrary value
    parameter logic [31:0] STD_ID    = 32'h3c4d5e6f  // Arbitrary value
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        ce_n,
    input  wire logic        sck,
    input  wire logic        si,
    input  wire logic        wp_n,
    output logic             so,
    output logic             so_oe,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    logic [1:0] rst_q;
    logic       rst_n;
    sfc_state_t st;
    sfc_state_t next_st;
    logic       ce_fall;
    logic       ce_rise;
    logic       sck_rise;
    logic       sck_fall;
    logic [7:0] byte_in;
    logic       busy;
    logic       awake;
    logic       low_pwr;
    logic       wr_go;

    function automatic logic [7:0] status_of(input sfc_state_t s, input logic b);
        logic [7:0] r;
        r = 8'h00;
        r[ST_BUSY_POS] = b;
        r[ST_WEL_POS] = s.wel;
        r[ST_BP_POS +: 3] = s.bp;
        r[ST_TB_POS] = s.tb;
        r[ST_BPL_POS] = s.status_lockdown_bit;
        return r;
    endfunction

    function automatic logic [7:0] id_byte(input logic [1:0] i);
        logic [7:0] r;
        r = 8'h00;
        unique case (i)
            2'd0: r = STD_ID[31:24];
            2'd1: r = STD_ID[23:16];
            2'd2: r = STD_ID[15:8];
            2'd3: r = STD_ID[7:0];
        endcase
        return r;
    endfunction

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    assign ce_fall  = !st.ce_s && st.ce_q;
    assign ce_rise  = st.ce_s && !st.ce_q;
    assign sck_rise = st.sck_s && !st.sck_q && !st.ce_s;
    assign sck_fall = !st.sck_s && st.sck_q && !st.ce_s;
    assign byte_in  = {st.shreg[6:0], st.si_s};  // MSB first
    assign busy     = (st.wr_cnt != 16'h0) || st.ext_busy;
    assign awake    = !st.sleep && st.pwr_cnt == 16'h0;
    assign low_pwr  = st.sleep && st.pwr_cnt == 16'h0;
    // Lock check at the closing edge
    assign wr_go    = st.byte_cnt == 2'd1 && st.bit_cnt == 3'h0 && !busy && st.wel
                      && !(!st.wp_s && st.status_lockdown_bit);

    always_comb begin
        next_st = st;
        next_st.ce_m = ce_n;
        next_st.ce_s = st.ce_m;
        next_st.ce_q = st.ce_s;
        next_st.sck_m = sck;
        next_st.sck_s = st.sck_m;
        next_st.sck_q = st.sck_s;
        next_st.si_m = si;
        next_st.si_s = st.si_m;
        next_st.wp_m = wp_n;
        next_st.wp_s = st.wp_m;
        if (st.wr_cnt != 16'h0) begin
            next_st.wr_cnt = st.wr_cnt - 16'h1;  // Self-timed status write
        end
        if (st.pwr_cnt != 16'h0) begin
            next_st.pwr_cnt = st.pwr_cnt - 16'h1;  // Entry / recovery delay
        end

        if (ce_fall) begin
            next_st.phase = PH_CMD;
            next_st.bit_cnt = 3'h0;
            next_st.byte_cnt = 2'd0;
            next_st.cmd_ok = 1'b0;
            next_st.ocnt = 3'h0;
        end else if (ce_rise) begin
            next_st.phase = PH_IDLE;
            next_st.so_oe = 1'b0;  // Output ends even mid-byte
            if (st.cmd_ok) begin
                unique case (st.opcode)
                    OP_WRITE_ENABLE: begin
                        if (st.byte_cnt == 2'd0 && st.bit_cnt == 3'h0) begin
                            next_st.wel = 1'b1;
                        end
                    end
                    OP_WRITE_DISABLE: begin
                        if (st.byte_cnt == 2'd0 && st.bit_cnt == 3'h0) begin
                            next_st.wel = 1'b0;
                        end
                    end
                    OP_STATUS_WRITE: begin
                        if (st.bit_cnt == 3'h0) begin
                            next_st.wel = 1'b0;
                        end
                        if (wr_go) begin
                            // Only the five writable bits change
                            next_st.bp = st.wdata[ST_BP_POS +: 3];
                            next_st.tb = st.wdata[ST_TB_POS];
                            next_st.status_lockdown_bit = st.wp_s ? st.wdata[ST_BPL_POS]
                                                  : st.status_lockdown_bit | st.wdata[ST_BPL_POS];
                            next_st.wr_cnt = STATUS_WRITE_CYC;
                        end
                    end
                    OP_DEEP_SLEEP: begin
                        if (st.byte_cnt == 2'd0 && st.bit_cnt == 3'h0 && !busy) begin
                            next_st.sleep = 1'b1;
                            next_st.pwr_cnt = SLEEP_ENTRY_CYC;
                        end
                    end
                    OP_RELEASE_ID: begin
                        if (st.sleep) begin
                            next_st.sleep = 1'b0;
                            next_st.pwr_cnt = SLEEP_RECOV_CYC;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else if (sck_rise) begin
            next_st.shreg = byte_in;
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == 3'h7) begin
                unique case (st.phase)
                    PH_CMD: begin
                        next_st.opcode = byte_in;
                        next_st.phase = PH_IDLE;
                        // Asleep or recovering: only release / legacy id
                        next_st.cmd_ok = awake || byte_in == OP_RELEASE_ID;
                        if (awake || byte_in == OP_RELEASE_ID) begin
                            unique case (byte_in)
                                OP_STATUS_READ: begin
                                    next_st.phase = PH_OUT;  // Allowed while busy
                                    next_st.cur = status_of(st, busy);
                                end
                                OP_STD_ID: begin
                                    next_st.phase = PH_OUT;
                                    next_st.cur = id_byte(2'd0);
                                    next_st.idx = 2'd1;
                                end
                                OP_RELEASE_ID: begin
                                    next_st.phase = PH_ADDR;
                                end
                                OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_STATUS_WRITE, OP_DEEP_SLEEP: begin
                                    next_st.phase = PH_DATA;
                                end
                                default: begin
                                    next_st.cmd_ok = 1'b0;
                                end
                            endcase
                        end
                    end
                    PH_ADDR: begin
                        next_st.byte_cnt = st.byte_cnt + 2'd1;
                        if (st.byte_cnt == 2'd2) begin
                            next_st.phase = PH_OUT;  // After 24 dummy bits
                            next_st.cur = LEGACY_ID;
                        end
                    end
                    PH_DATA: begin
                        if (st.byte_cnt == 2'd0) begin
                            next_st.wdata = byte_in;
                        end
                        if (st.byte_cnt != 2'd2) begin
                            next_st.byte_cnt = st.byte_cnt + 2'd1;  // Extra bytes
                        end
                    end
                    PH_IDLE, PH_OUT: begin
                    end
                endcase
            end
        end else if (sck_fall && st.phase == PH_OUT) begin
            next_st.so = st.cur[7];  // Drive on falling edge
            next_st.so_oe = 1'b1;
            next_st.cur = {st.cur[6:0], 1'b0};
            next_st.ocnt = st.ocnt + 3'h1;
            if (st.ocnt == 3'h7) begin
                if (st.opcode == OP_STATUS_READ) begin
                    next_st.cur = status_of(st, busy);  // Live status each byte
                end else if (st.opcode == OP_STD_ID) begin
                    next_st.cur = id_byte(st.idx);  // Wraps after the fourth
                    next_st.idx = st.idx + 2'd1;
                end else begin
                    next_st.cur = LEGACY_ID;
                end
            end
        end

        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        if (psel && penable && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0;
            if (paddr == REG_STATUS) begin
                next_st.prdata = {21'h0, awake, low_pwr, st.sleep, status_of(st, busy)};
            end else if (paddr == REG_CONTROL) begin
                next_st.prdata[CTL_EXT_BUSY_POS] = st.ext_busy;
            end else begin
                next_st.pslverr = 1'b1;
            end
        end
        if (psel && penable && st.pready && pwrite && paddr == REG_CONTROL) begin
            next_st.ext_busy = pwdata[CTL_EXT_BUSY_POS];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.ce_m <= 1'b1;  // Pins start at idle level: no false edge
            st.ce_s <= 1'b1;
            st.ce_q <= 1'b1;
            st.wp_m <= 1'b1;
            st.wp_s <= 1'b1;
            st.phase <= PH_IDLE;
            st.bp <= PROTECT_RST;
        end else begin
            st <= next_st;
        end
    end

    assign so      = st.so;
    assign so_oe   = st.so_oe;
    assign prdata  = st.prdata;
    assign pready  = st.pready;
    assign pslverr = st.pslverr;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_wel_set: assert property (ce_rise && st.cmd_ok && st.opcode == OP_WRITE_ENABLE
        && st.byte_cnt == 2'd0 && st.bit_cnt == 3'h0 |=> st.wel)
        else $error("write enable did not set latch");
    a_wel_clear: assert property (ce_rise && st.cmd_ok && st.opcode == OP_WRITE_DISABLE
        && st.byte_cnt == 2'd0 && st.bit_cnt == 3'h0 |=> !st.wel)
        else $error("write disable did not clear latch");
    a_status_write_cmd_wel: assert property (ce_rise && st.cmd_ok && st.opcode == OP_STATUS_WRITE && st.bit_cnt == 3'h0
        |=> !st.wel)
        else $error("status write left latch set");
    a_locked_status: assert property (ce_rise && !st.wp_s && st.status_lockdown_bit
        |=> $stable(st.bp) && $stable(st.tb) && st.status_lockdown_bit && st.wr_cnt != STATUS_WRITE_CYC)
        else $error("locked status register changed");
    a_bpl_sticky: assert property (st.status_lockdown_bit && !st.wp_s && !ce_rise |=> st.status_lockdown_bit)
        else $error("lock-down bit cleared while protected");
    a_sleep_busy: assert property (ce_rise && busy && !st.sleep |=> !st.sleep)
        else $error("deep sleep entered while busy");
    a_sleep_entry: assert property ($rose(st.sleep) |-> !low_pwr [*8])
        else $error("low power reached before entry delay");
    a_write_busy: assert property (st.wr_cnt == STATUS_WRITE_CYC
        |-> busy ##1 (st.wr_cnt == STATUS_WRITE_CYC - 16'h1))
        else $error("status write timer not running");
    a_out_ends: assert property (ce_rise |=> !st.so_oe && st.phase == PH_IDLE)
        else $error("output not ended by chip enable");
    a_partial_byte: assert property (ce_rise && st.bit_cnt != 3'h0 && st.opcode != OP_RELEASE_ID
        |=> $stable(st.wel) && $stable(st.sleep) && $stable(st.bp))
        else $error("partial byte command acted upon");
    // Decode, status write, sleep and output timing
    a_status_live: assert property (sck_rise && st.phase == PH_CMD && st.bit_cnt == 3'h7 && awake
        && byte_in == OP_STATUS_READ |=> st.phase == PH_OUT && st.cur[ST_BUSY_POS] == $past(busy))
        else $error("status read not answered with live busy");
    a_sleep_filter: assert property (sck_rise && st.phase == PH_CMD && st.bit_cnt == 3'h7 && !awake
        && byte_in != OP_RELEASE_ID |=> !st.cmd_ok)
        else $error("command accepted while asleep");
    a_status_update: assert property (ce_rise && st.cmd_ok && st.opcode == OP_STATUS_WRITE && wr_go
        |=> st.bp == $past(st.wdata[ST_BP_POS +: 3]) && st.tb == $past(st.wdata[ST_TB_POS]))
        else $error("status write did not update protect bits");
    a_open_lockdown: assert property (ce_rise && st.cmd_ok && st.opcode == OP_STATUS_WRITE && wr_go
        && st.wp_s |=> st.status_lockdown_bit == $past(st.wdata[ST_BPL_POS]))
        else $error("lock-down bit not free with protect pin high");
    a_sleep_enter: assert property (ce_rise && st.cmd_ok && st.opcode == OP_DEEP_SLEEP && !busy
        && st.byte_cnt == 2'd0 && st.bit_cnt == 3'h0 |=> st.sleep && st.pwr_cnt == SLEEP_ENTRY_CYC)
        else $error("deep sleep not entered");
    a_wake_release: assert property (ce_rise && st.cmd_ok && st.opcode == OP_RELEASE_ID && st.sleep
        |=> !st.sleep && st.pwr_cnt == SLEEP_RECOV_CYC)
        else $error("release did not leave deep sleep");
    a_legacy_id: assert property (sck_rise && st.phase == PH_ADDR && st.bit_cnt == 3'h7
        && st.byte_cnt == 2'd2 |=> st.phase == PH_OUT && st.cur == LEGACY_ID)
        else $error("legacy identifier not loaded after dummy bits");
    a_std_id_first: assert property (sck_rise && st.phase == PH_CMD && st.bit_cnt == 3'h7 && awake
        && byte_in == OP_STD_ID |=> st.phase == PH_OUT && st.cur == STD_ID[31:24] && st.idx == 2'd1)
        else $error("identifier does not start with maker byte");
    a_extra_data: assert property (ce_rise && st.opcode == OP_STATUS_WRITE && st.byte_cnt == 2'd2
        |=> $stable(st.bp) && $stable(st.tb) && $stable(st.status_lockdown_bit))
        else $error("long status write changed status");
    a_drive_fall: assert property ($changed(st.so) |-> $past(sck_fall))
        else $error("serial output changed off the clock fall");
endmodule

// ===== verif/sfc_host_model.sv
// Behavioural host SPI controller (mode 0, MSB first) for the flash block.
// Assumes the testbench calls frame() and watches frame_done for rx.
module sfc_host_model (
    output logic      ce_n,
    output logic      sck,
    output logic      si,
    input  wire logic so
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [63:0] rx;
    event        frame_done;

    initial begin
        ce_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
        rx   = '0;
    end

    // Clock stands low between frames; low phase long enough for late so
    task automatic frame(input int nbits, input logic [63:0] tx);
        #7;
        ce_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            si = tx[63 - i];
            #130;
            sck = 1'b1;
            rx  = {rx[62:0], so};
            #70;
            sck = 1'b0;
        end
        #130;
        ce_n = 1'b1;
        si   = ~si;
        -> frame_done;
        #250;
    endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench of the flash command block: SPI host model plus APB.
// Assumes the block answers APB with one wait state and SPI per its note.
module testbench
    import sfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0]  ID_LEG = 8'h5a;        // Arbitrary value
    localparam logic [31:0] ID_STD = 32'h1234abcd; // Arbitrary value

    logic        sys_clk, reset_n, wp_n, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_data, seed;
    logic        pready, pslverr, so, so_oe, ce_n, sck, si;
    logic [32:0] apb_exp[$], apb_msk[$];
    logic [39:0] spi_exp[$], spi_msk[$];
    int          n_errors, check_count, k;

    sfc_flash_cmd #(.LEGACY_ID(ID_LEG), .STD_ID(ID_STD)) uut (
        .sys_clk(sys_clk), .reset_n(reset_n), .ce_n(ce_n), .sck(sck), .si(si), .wp_n(wp_n),
        .so(so), .so_oe(so_oe), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sfc_host_model host (.ce_n(ce_n), .sck(sck), .si(si), .so(so_oe ? so : ~so));

    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic limit_hit;
        n_errors++;
        $display("ERROR %0t: wait limit reached", $time);
        complete_run;
    endtask

    always @(posedge sys_clk) if (psel && penable && pready === 1'b1)
        check({7'h0, {pslverr, prdata} & apb_msk.pop_front()}, {7'h0, apb_exp.pop_front()});
    always @(host.frame_done)
        check(host.rx[39:0] & spi_msk.pop_front(), spi_exp.pop_front());

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] m, input logic [32:0] e);
        int n;
        apb_msk.push_back(m);
        apb_exp.push_back(e);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) limit_hit();
        rd_data = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic spi(input int nb, input logic [63:0] tx, input logic [39:0] m, input logic [39:0] e);
        spi_msk.push_back(m);
        spi_exp.push_back(e);
        host.frame(nb, tx);
        @(posedge sys_clk);
    endtask

    task automatic cmd(input logic [7:0] op);
        spi(8, {op, 56'h0}, 40'h0, 40'h0);
    endtask

    task automatic st(input logic [7:0] e);
        spi(24, {OP_STATUS_READ, 56'h0}, 40'hffff, {24'h0, e, e});
    endtask

    task automatic wsr(input logic [7:0] d);
        cmd(OP_WRITE_ENABLE);
        spi(16, {OP_STATUS_WRITE, d, 48'h0}, 40'h0, 40'h0);
    endtask

    // Polls busy over APB with a bound
    task automatic wait_idle;
        for (k = 0; k < 100; k++) begin
            apb(1'b0, REG_STATUS, 32'h0, 33'h0, 33'h0);
            if (rd_data[0] === 1'b0) break;
        end
        if (k == 100) limit_hit();
    endtask

    initial begin
        reset_n = 1'b0;
        wp_n = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        n_errors = 0;
        check_count = 0;
        seed = 32'd6953;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        apb(1'b0, REG_STATUS, 32'h0, 33'h7ff, 33'h400);
        apb(1'b0, 8'h08, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
        apb(1'b1, REG_STATUS, 32'hff, 33'h0, 33'h0);
        apb(1'b0, REG_STATUS, 32'h0, 33'hff, 33'h0);
        st(8'h00);
        cmd(OP_WRITE_ENABLE);
        st(8'h02);
        cmd(OP_WRITE_DISABLE);
        st(8'h00);
        spi(16, {OP_WRITE_ENABLE, 56'h0}, 40'h0, 40'h0);
        st(8'h00);
        cmd(OP_WRITE_ENABLE);
        spi(12, {OP_WRITE_DISABLE, 56'h0}, 40'h0, 40'h0);
        st(8'h02);
        seed = xs(seed);
        wsr(seed[7:0]);
        spi(24, {OP_STATUS_READ, 56'h0}, 40'hff00, {24'h0, (seed[7:0] & 8'hbc) | 8'h01, 8'h0});
        wait_idle();
        st(seed[7:0] & 8'hbc);
        wsr(8'hbc);
        wait_idle();
        wp_n <= 1'b0;
        wsr(8'h00);
        wait_idle();
        st(8'hbc);
        wp_n <= 1'b1;
        wsr(8'h00);
        wait_idle();
        st(8'h00);
        wp_n <= 1'b0;
        wsr(8'h84);
        wait_idle();
        st(8'h84);
        wp_n <= 1'b1;
        cmd(OP_WRITE_ENABLE);
        spi(24, {OP_STATUS_WRITE, 16'h0, 40'h0}, 40'h0, 40'h0);
        wait_idle();
        st(8'h84);
        wsr(8'h00);
        wait_idle();
        spi(48, {OP_STD_ID, 56'h0}, 40'hff_ffff_ffff, {ID_STD, ID_STD[31:24]});
        spi(20, {OP_STD_ID, 56'h0}, 40'hfff, {28'h0, ID_STD[31:20]});
        check({39'h0, so_oe}, 40'h0);
        spi(48, {OP_RELEASE_ID, 56'h0}, 40'hffff, {24'h0, ID_LEG, ID_LEG});
        apb(1'b1, REG_CONTROL, 32'h1, 33'h0, 33'h0);
        apb(1'b0, REG_CONTROL, 32'h0, 33'h1, 33'h1);
        st(8'h01);
        cmd(OP_DEEP_SLEEP);
        apb(1'b0, REG_STATUS, 32'h0, 33'h100, 33'h0);
        apb(1'b1, REG_CONTROL, 32'h0, 33'h0, 33'h0);
        cmd(OP_DEEP_SLEEP);
        apb(1'b0, REG_STATUS, 32'h0, 33'h300, 33'h100);
        repeat (125) @(posedge sys_clk);
        apb(1'b0, REG_STATUS, 32'h0, 33'h300, 33'h300);
        cmd(OP_WRITE_ENABLE);
        apb(1'b0, REG_STATUS, 32'h0, 33'h302, 33'h300);
        cmd(OP_RELEASE_ID);
        apb(1'b0, REG_STATUS, 32'h0, 33'h400, 33'h0);
        repeat (125) @(posedge sys_clk);
        apb(1'b0, REG_STATUS, 32'h0, 33'h7ff, 33'h400);
        st(8'h00);
        repeat (4) @(posedge sys_clk);
        complete_run();
    end
endmodule
